// *** hdl/hib_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the hibernation controller.
// Assumes inclusion by bare name from the package and the design file.
`ifndef HIB_DEFINES_SVH
`define HIB_DEFINES_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define HIB_CTRL_OFS 12'h000
`define HIB_RTC_OFS 12'h004
`define HIB_TRIM_OFS 12'h008
`define HIB_MATCH0_OFS 12'h00c
`define HIB_MATCH1_OFS 12'h010
`define HIB_IRQ_EN_OFS 12'h014
`define HIB_RAW_ST_OFS 12'h018
`define HIB_MSK_ST_OFS 12'h01c
`define HIB_CLEAR_OFS 12'h020
`define HIB_STATUS_OFS 12'h024
`define HIB_MEM_OFS 12'h100
`define HIB_MEM_END 12'h1fc
// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define CTL_ENABLE 0
`define CTL_RTC_EN 1
`define CTL_WAKE_PIN 2
`define CTL_WAKE_RTC 3
`define CTL_ABORT_LOW 4
`define CTL_HIB_REQ 5
`define CTL_BAT_CHECK 6
`define CTL_DRV_OFF 7
`define CTL_DRV_STRONG 8
`define CTL_WIDTH 9
`define CTL_RESET 9'h100
// Event flag positions
`define EVT_PIN 0
`define EVT_LOWBAT 1
`define EVT_MATCH0 2
`define EVT_MATCH1 3
`define EVT_WIDTH 4
// Status positions
`define ST_CHECKING 0
`define ST_ASLEEP 1
`define ST_ACTIVE 2
// ----------------------------------------------------------------------------
// Counts and reset values
// ----------------------------------------------------------------------------
`define TRIM_RESET 16'h7fff
`define TRIM_UNITY 16'h7fff
`define WORD_ZERO 32'h0000_0000
`define MATCH_RESET 32'hffff_ffff
`define BAT_CHECK_CYCLES 8'h10
`define POWER_DOWN_CYCLES 8'h08
`endif

// *** hdl/hib_pkg.sv ***
// Types shared by the hibernation controller.
// Assumes hib_defines.svh is on the include path.
`include "hib_defines.svh"
package hib_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_DOWN = 2'b10,
    ST_SLEEP = 2'b11
  } seq_t;
endpackage

// *** hdl/hibernation_power_controller.sv ***
// Always-on hibernation controller: RTC, match, retained words, events and power sequencing.
// Assumes an APB master on CLK and RESET_N as the always-on domain reset.
`timescale 1ns/1ps
`include "hib_defines.svh"
module hibernation_power_controller #(
  parameter int MEM_WORDS = 64,
  parameter int CHECK_CYCLES = `BAT_CHECK_CYCLES,
  parameter int DOWN_CYCLES = `POWER_DOWN_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire hib_pkg::apb_req_t APB_REQ,
  output hib_pkg::apb_rsp_t APB_RSP,
  input wire logic WAKE_PIN,
  input wire logic BATTERY_LOW,
  output logic PROC_POWER_EN,
  output logic CRYSTAL_DRIVER_OFF,
  output logic CRYSTAL_STRONG_DRIVE,
  output logic CRYSTAL_WEAK_DRIVE,
  output logic HIB_IRQ
);
  import hib_pkg::*;

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [`CTL_WIDTH-1:0] ctrl;
  logic [31:0] rtc;
  logic [15:0] trim;
  logic [15:0] frac;
  logic [31:0] match0;
  logic [31:0] match1;
  logic [`EVT_WIDTH-1:0] irq_en;
  logic [`EVT_WIDTH-1:0] raw;
  logic [31:0] mem [MEM_WORDS];
  logic [7:0] chk_cnt;
  logic [7:0] dn_cnt;
  logic checking;
  logic active;
  logic req_pend;
  seq_t state;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic wr;
  logic rd;
  logic [11:0] addr;
  logic in_mem;
  logic [5:0] widx;
  logic [`EVT_WIDTH-1:0] set_evt;
  logic [`EVT_WIDTH-1:0] clr_evt;
  logic [16:0] frac_sum;
  logic tick;
  logic wake_hit;
  logic ctrl_wr;
  logic rtc_wr;

  assign addr = APB_REQ.paddr;
  assign wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign rd = APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite;
  assign in_mem = (addr >= `HIB_MEM_OFS) && (addr <= `HIB_MEM_END);
  assign widx = addr[7:2];
  assign ctrl_wr = wr && (addr == `HIB_CTRL_OFS);
  assign rtc_wr = wr && (addr == `HIB_RTC_OFS);
  assign clr_evt = (wr && (addr == `HIB_CLEAR_OFS)) ? APB_REQ.pwdata[`EVT_WIDTH-1:0] : '0;

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  // Request and check bits self-clear so software sees them as commands
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= `CTL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= APB_REQ.pwdata[`CTL_WIDTH-1:0];
      ctrl[`CTL_HIB_REQ] <= 1'b0;
      ctrl[`CTL_BAT_CHECK] <= 1'b0;
    end
  end

  // Crystal drive pins, decoded from enable and drive bits
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CRYSTAL_DRIVER_OFF <= 1'b0;
      CRYSTAL_STRONG_DRIVE <= 1'b0;
      CRYSTAL_WEAK_DRIVE <= 1'b0;
    end else begin
      CRYSTAL_DRIVER_OFF <= !ctrl[`CTL_ENABLE] || ctrl[`CTL_DRV_OFF];
      CRYSTAL_STRONG_DRIVE <= ctrl[`CTL_ENABLE] && !ctrl[`CTL_DRV_OFF]
                              && ctrl[`CTL_DRV_STRONG];
      CRYSTAL_WEAK_DRIVE <= ctrl[`CTL_ENABLE] && !ctrl[`CTL_DRV_OFF]
                            && !ctrl[`CTL_DRV_STRONG];
    end
  end

  // --------------------------------------------------------------------------
  // Real-time counter with trim
  // --------------------------------------------------------------------------
  // Fractional accumulator: unity trim ticks every cycle, smaller trims skip
  assign frac_sum = {1'b0, frac} + {1'b0, trim} + 17'h00001;
  assign tick = frac_sum[16] || (trim == `TRIM_UNITY);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      trim <= `TRIM_RESET;
    end else if (wr && (addr == `HIB_TRIM_OFS)) begin
      trim <= APB_REQ.pwdata[15:0];
    end
  end

  // Load wins over counting
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rtc <= `WORD_ZERO;
      frac <= 16'h0000;
    end else if (rtc_wr) begin
      rtc <= APB_REQ.pwdata;
      frac <= 16'h0000;
    end else if (ctrl[`CTL_ENABLE] && ctrl[`CTL_RTC_EN]) begin
      frac <= frac_sum[15:0];
      if (tick) begin
        rtc <= rtc + 32'h0000_0001;
      end
    end
  end

  // Match values
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      match0 <= `MATCH_RESET;
      match1 <= `MATCH_RESET;
    end else if (wr) begin
      if (addr == `HIB_MATCH0_OFS) begin
        match0 <= APB_REQ.pwdata;
      end
      if (addr == `HIB_MATCH1_OFS) begin
        match1 <= APB_REQ.pwdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Retained words
  // --------------------------------------------------------------------------
  // Cleared only by always-on reset, kept across sleep
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= `WORD_ZERO;
      end
    end else if (wr && in_mem) begin
      mem[widx] <= APB_REQ.pwdata;
    end
  end

  // --------------------------------------------------------------------------
  // Battery check
  // --------------------------------------------------------------------------
  // Forced check runs a fixed window and samples the comparator at its end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      checking <= 1'b0;
      chk_cnt <= 8'h00;
    end else if (!checking && ctrl_wr && APB_REQ.pwdata[`CTL_BAT_CHECK]) begin
      checking <= 1'b1;
      chk_cnt <= 8'(CHECK_CYCLES - 1);
    end else if (checking) begin
      if (chk_cnt == 8'h00) begin
        checking <= 1'b0;
      end else begin
        chk_cnt <= chk_cnt - 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Event flags
  // --------------------------------------------------------------------------
  always_comb begin
    set_evt = '0;
    set_evt[`EVT_PIN] = WAKE_PIN && ctrl[`CTL_ENABLE];
    set_evt[`EVT_LOWBAT] = checking && (chk_cnt == 8'h00) && BATTERY_LOW;
    set_evt[`EVT_MATCH0] = ctrl[`CTL_RTC_EN] && (rtc == match0);
    set_evt[`EVT_MATCH1] = ctrl[`CTL_RTC_EN] && (rtc == match1);
  end

  // Sticky flags, set beats clear in the same cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      raw <= '0;
    end else begin
      raw <= (raw & ~clr_evt) | set_evt;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_en <= '0;
    end else if (wr && (addr == `HIB_IRQ_EN_OFS)) begin
      irq_en <= APB_REQ.pwdata[`EVT_WIDTH-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HIB_IRQ <= 1'b0;
    end else begin
      HIB_IRQ <= |(raw & irq_en);
    end
  end

  // --------------------------------------------------------------------------
  // Power sequencer
  // --------------------------------------------------------------------------
  assign wake_hit = (ctrl[`CTL_WAKE_PIN] && WAKE_PIN)
                    || (ctrl[`CTL_WAKE_RTC] && (set_evt[`EVT_MATCH0] || set_evt[`EVT_MATCH1]));

  // Active status follows the enable bit, one cycle behind it
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      active <= 1'b0;
    end else begin
      active <= ctrl[`CTL_ENABLE];
    end
  end

  // Request is held while checking and dropped if battery low with abort set
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= ST_RUN;
      dn_cnt <= 8'h00;
      PROC_POWER_EN <= 1'b1;
    end else begin
      case (state)
        ST_RUN: begin
          if (ctrl_wr && APB_REQ.pwdata[`CTL_HIB_REQ] && ctrl[`CTL_ENABLE]) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (ctrl[`CTL_ABORT_LOW] && (BATTERY_LOW || raw[`EVT_LOWBAT])) begin
            state <= ST_RUN;
          end else if (!checking) begin
            state <= ST_DOWN;
            dn_cnt <= 8'(DOWN_CYCLES - 1);
          end
        end
        ST_DOWN: begin
          if (dn_cnt == 8'h00) begin
            state <= ST_SLEEP;
            PROC_POWER_EN <= 1'b0;
          end else begin
            dn_cnt <= dn_cnt - 8'h01;
          end
        end
        ST_SLEEP: begin
          if (wake_hit) begin
            state <= ST_RUN;
            PROC_POWER_EN <= 1'b1;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  assign req_pend = (state == ST_HOLD);

  // --------------------------------------------------------------------------
  // APB read path
  // --------------------------------------------------------------------------
  // Zero wait states: data latched in setup, valid in access
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      APB_RSP <= '0;
    end else begin
      APB_RSP.pready <= APB_REQ.psel && !APB_REQ.penable;
      APB_RSP.pslverr <= 1'b0;
      if (rd) begin
        APB_RSP.prdata <= `WORD_ZERO;
        if (in_mem) begin
          APB_RSP.prdata <= mem[widx];
        end else begin
          case (addr)
            `HIB_CTRL_OFS: APB_RSP.prdata <= 32'(ctrl);
            `HIB_RTC_OFS: APB_RSP.prdata <= rtc;
            `HIB_TRIM_OFS: APB_RSP.prdata <= 32'(trim);
            `HIB_MATCH0_OFS: APB_RSP.prdata <= match0;
            `HIB_MATCH1_OFS: APB_RSP.prdata <= match1;
            `HIB_IRQ_EN_OFS: APB_RSP.prdata <= 32'(irq_en);
            `HIB_RAW_ST_OFS: APB_RSP.prdata <= 32'(raw);
            `HIB_MSK_ST_OFS: APB_RSP.prdata <= 32'(raw & irq_en);
            `HIB_STATUS_OFS: APB_RSP.prdata <= 32'({active, req_pend, checking});
            default: APB_RSP.prdata <= `WORD_ZERO;
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_check_start;
    ctrl_wr && APB_REQ.pwdata[`CTL_BAT_CHECK] && !checking;
  endsequence

  a_check_busy: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_check_start |=> checking [*8]) else $error("check ended early");
  a_flag_sticky: assert property (@(posedge CLK) disable iff (!RESET_N)
    raw[`EVT_PIN] && !clr_evt[`EVT_PIN] |=> raw[`EVT_PIN]) else $error("flag lost");
  a_match_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
    set_evt[`EVT_MATCH0] |=> raw[`EVT_MATCH0]) else $error("match flag missing");
  a_hold_check: assert property (@(posedge CLK) disable iff (!RESET_N)
    (state == ST_HOLD) && checking |=> state != ST_DOWN) else $error("request not held");
  a_rtc_stop: assert property (@(posedge CLK) disable iff (!RESET_N)
    !ctrl[`CTL_RTC_EN] && !rtc_wr |=> $stable(rtc)) else $error("rtc moved");
  a_rtc_load: assert property (@(posedge CLK) disable iff (!RESET_N)
    rtc_wr |=> rtc == $past(APB_REQ.pwdata)) else $error("rtc load lost");
  a_wake_power: assert property (@(posedge CLK) disable iff (!RESET_N)
    (state == ST_SLEEP) && wake_hit |=> PROC_POWER_EN) else $error("no wake");
  a_irq_mask: assert property (@(posedge CLK) disable iff (!RESET_N)
    ((raw & irq_en) == '0) |=> !HIB_IRQ) else $error("masked irq seen");
  a_low_abort: assert property (@(posedge CLK) disable iff (!RESET_N)
    (state == ST_HOLD) && ctrl[`CTL_ABORT_LOW] && BATTERY_LOW |=> state == ST_RUN)
    else $error("abort ignored");

  // Power removal steps: request taken, countdown ends, supply drops
  sequence s_req_taken;
    ctrl_wr && APB_REQ.pwdata[`CTL_HIB_REQ] && ctrl[`CTL_ENABLE] && (state == ST_RUN);
  endsequence

  sequence s_down_last;
    (state == ST_DOWN) && (dn_cnt == 8'h00);
  endsequence

  a_req_taken: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_req_taken |=> state == ST_HOLD) else $error("request not taken");
  a_power_off: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_down_last |=> !PROC_POWER_EN && (state == ST_SLEEP)) else $error("power not removed");
  a_check_end: assert property (@(posedge CLK) disable iff (!RESET_N)
    checking && (chk_cnt == 8'h00) |=> !checking) else $error("check never ends");
  a_lowbat_set: assert property (@(posedge CLK) disable iff (!RESET_N)
    checking && (chk_cnt == 8'h00) && BATTERY_LOW |=> raw[`EVT_LOWBAT])
    else $error("low battery flag missing");
  // A clear with no new event must really drop the flag
  a_flag_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
    clr_evt[`EVT_PIN] && !set_evt[`EVT_PIN] |=> !raw[`EVT_PIN]) else $error("flag not cleared");
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the hibernation controller: registers, counter, events, sequencing.
// Assumes hib_pkg and hib_defines.svh are compiled and on the include path.
`timescale 1ns/1ps
`include "hib_defines.svh"
module tb;
  import hib_pkg::*;
  // --------------------------------------------------------------------------
  // Stimulus signals and design
  // --------------------------------------------------------------------------
  localparam logic [31:0] EN = 32'h1 << `CTL_ENABLE;
  localparam logic [31:0] RTC = 32'h1 << `CTL_RTC_EN;
  localparam logic [31:0] WPIN = 32'h1 << `CTL_WAKE_PIN;
  localparam logic [31:0] WRTC = 32'h1 << `CTL_WAKE_RTC;
  localparam logic [31:0] ABT = 32'h1 << `CTL_ABORT_LOW;
  localparam logic [31:0] REQ = 32'h1 << `CTL_HIB_REQ;
  localparam logic [31:0] CHK = 32'h1 << `CTL_BAT_CHECK;
  localparam logic [31:0] OFF = 32'h1 << `CTL_DRV_OFF;
  localparam logic [31:0] STR = 32'h1 << `CTL_DRV_STRONG;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic wake_pin = 1'b0;
  logic battery_low = 1'b0;
  logic power_en, drv_off, drv_strong, drv_weak, irq;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  logic [31:0] rd, a;
  logic err;
  always #12.5 clk = ~clk;
  hibernation_power_controller #(.MEM_WORDS(64), .CHECK_CYCLES(16), .DOWN_CYCLES(8)) i_dut (
    .CLK(clk), .RESET_N(reset_n), .APB_REQ(req), .APB_RSP(rsp), .WAKE_PIN(wake_pin),
    .BATTERY_LOW(battery_low), .PROC_POWER_EN(power_en), .CRYSTAL_DRIVER_OFF(drv_off),
    .CRYSTAL_STRONG_DRIVE(drv_strong), .CRYSTAL_WEAK_DRIVE(drv_weak), .HIB_IRQ(irq));
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, well above the thousand or so cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      complete_run;
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{paddr: ad, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (k >= 50) check("pready", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rdchk(input string w, input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    check(w, e, rd);
    check("slverr", 32'h0, 32'(err));
  endtask
  // Polls the power output; n returns the cycles spent
  task automatic wait_pwr(input logic v, input int max);
    n = 0;
    while (power_en !== v && n < max) begin
      @(posedge clk);
      n++;
    end
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    rdchk("ctrl", `HIB_CTRL_OFS, 32'h100);
    rdchk("trim", `HIB_TRIM_OFS, 32'h7fff);
    rdchk("match1", `HIB_MATCH1_OFS, 32'hffff_ffff);
    rdchk("raw", `HIB_RAW_ST_OFS, 32'h0);
    rdchk("cold status", `HIB_STATUS_OFS, 32'h0);
    wr(12'h040, 32'hdead_beef);
    rdchk("unmapped", 12'h040, 32'h0);
    check("osc off", 32'h1, 32'(drv_off));
    $display("test reset done");
  endtask
  task automatic t_mem;
    for (int i = 0; i < 64; i++) wr(`HIB_MEM_OFS + 12'(4 * i), 32'ha500_0000 | i);
    for (int i = 0; i < 64; i++) rdchk("mem", `HIB_MEM_OFS + 12'(4 * i), 32'ha500_0000 | i);
    $display("test mem done");
  endtask
  task automatic t_rtc;
    wr(`HIB_CTRL_OFS, EN);
    wr(`HIB_RTC_OFS, 32'hffff_fff0);
    repeat (5) @(posedge clk);
    rdchk("rtc held", `HIB_RTC_OFS, 32'hffff_fff0);
    wr(`HIB_CTRL_OFS, EN | RTC);
    apb(1'b0, `HIB_RTC_OFS, 32'h0);
    a = rd;
    apb(1'b0, `HIB_RTC_OFS, 32'h0);
    check("rtc step", 32'h1, {31'h0, (rd - a) >= 1 && (rd - a) <= 8});
    wr(`HIB_TRIM_OFS, 32'h3fff);
    rdchk("trim", `HIB_TRIM_OFS, 32'h3fff);
    wr(`HIB_TRIM_OFS, 32'h7fff);
    wr(`HIB_CTRL_OFS, EN);
    $display("test rtc done");
  endtask
  task automatic t_match;
    wr(`HIB_RTC_OFS, 32'h100);
    wr(`HIB_MATCH0_OFS, 32'h104);
    wr(`HIB_MATCH1_OFS, 32'h108);
    wr(`HIB_IRQ_EN_OFS, 32'h0);
    wr(`HIB_CLEAR_OFS, 32'hf);
    wr(`HIB_CTRL_OFS, EN | RTC);
    repeat (20) @(posedge clk);
    wr(`HIB_CTRL_OFS, EN);
    rdchk("raw", `HIB_RAW_ST_OFS, 32'hc);
    rdchk("masked", `HIB_MSK_ST_OFS, 32'h0);
    check("irq masked", 32'h0, 32'(irq));
    wr(`HIB_IRQ_EN_OFS, 32'h4);
    rdchk("masked", `HIB_MSK_ST_OFS, 32'h4);
    check("irq", 32'h1, 32'(irq));
    wr(`HIB_CLEAR_OFS, 32'h4);
    rdchk("raw", `HIB_RAW_ST_OFS, 32'h8);
    check("irq cleared", 32'h0, 32'(irq));
    wake_pin <= 1'b1;
    repeat (2) @(posedge clk);
    wake_pin <= 1'b0;
    rdchk("raw pin", `HIB_RAW_ST_OFS, 32'h9);
    wr(`HIB_CLEAR_OFS, 32'hf);
    rdchk("raw", `HIB_RAW_ST_OFS, 32'h0);
    $display("test match done");
  endtask
  task automatic t_bat;
    battery_low <= 1'b1;
    wr(`HIB_CTRL_OFS, EN | CHK);
    rdchk("checking", `HIB_STATUS_OFS, 32'h5);
    for (int i = 0; i < 20 && rd[`ST_CHECKING] !== 1'b0; i++) apb(1'b0, `HIB_STATUS_OFS, 32'h0);
    check("check done", 32'h4, rd);
    rdchk("raw lowbat", `HIB_RAW_ST_OFS, 32'h2);
    battery_low <= 1'b0;
    wr(`HIB_CLEAR_OFS, 32'hf);
    $display("test battery done");
  endtask
  task automatic t_abort;
    battery_low <= 1'b1;
    wr(`HIB_CTRL_OFS, EN | ABT | CHK);
    wr(`HIB_CTRL_OFS, EN | ABT | WPIN | REQ);
    wait_pwr(1'b0, 60);
    check("aborted", 32'h1, 32'(power_en));
    rdchk("raw lowbat", `HIB_RAW_ST_OFS, 32'h2);
    battery_low <= 1'b0;
    wr(`HIB_CLEAR_OFS, 32'hf);
    $display("test abort done");
  endtask
  task automatic t_hib_pin;
    wr(`HIB_CTRL_OFS, EN | CHK);
    wr(`HIB_CTRL_OFS, EN | WPIN | REQ);
    wait_pwr(1'b0, 60);
    check("held off", 32'h1, {31'h0, n >= 16 && n <= 40});
    check("powered down", 32'h0, 32'(power_en));
    wake_pin <= 1'b1;
    wait_pwr(1'b1, 10);
    wake_pin <= 1'b0;
    check("pin wake", 32'h1, 32'(power_en));
    rdchk("wake cause", `HIB_RAW_ST_OFS, 32'h1);
    rdchk("active", `HIB_STATUS_OFS, 32'h4);
    rdchk("mem kept", `HIB_MEM_OFS + 12'h0fc, 32'ha500_003f);
    wr(`HIB_CLEAR_OFS, 32'hf);
    $display("test pin wake done");
  endtask
  task automatic t_hib_rtc;
    wr(`HIB_CTRL_OFS, EN);
    wr(`HIB_RTC_OFS, 32'h200);
    wr(`HIB_MATCH0_OFS, 32'h228);
    wr(`HIB_CLEAR_OFS, 32'hf);
    wr(`HIB_CTRL_OFS, EN | RTC | WRTC | REQ);
    wait_pwr(1'b0, 30);
    check("powered down", 32'h0, 32'(power_en));
    wait_pwr(1'b1, 80);
    check("match wake", 32'h1, 32'(power_en));
    wr(`HIB_CTRL_OFS, EN);
    rdchk("wake cause", `HIB_RAW_ST_OFS, 32'h4);
    $display("test match wake done");
  endtask
  task automatic t_xtal;
    wr(`HIB_CTRL_OFS, EN | STR);
    repeat (2) @(posedge clk);
    check("strong", 32'h1, 32'(drv_strong));
    check("osc on", 32'h0, 32'(drv_off));
    wr(`HIB_CTRL_OFS, EN);
    repeat (2) @(posedge clk);
    check("weak", 32'h1, 32'({drv_strong, drv_weak}));
    wr(`HIB_CTRL_OFS, EN | OFF);
    repeat (2) @(posedge clk);
    check("osc off", 32'h1, 32'(drv_off));
    $display("test crystal done");
  endtask
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_mem;
    t_rtc;
    t_match;
    t_bat;
    t_abort;
    t_hib_pin;
    t_hib_rtc;
    t_xtal;
    complete_run;
  end
endmodule
